// *** faic_checker.sv ***
// Flash array integrity checker with signature register, breakpoints and APB registers.
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module faic_checker #(
  parameter int ADDR_W = 24
) (
  input  wire logic              I_REF_CLK,
  input  wire logic              I_RSTN,
  input  wire logic              I_PSEL,
  input  wire logic              I_PENABLE,
  input  wire logic              I_PWRITE,
  input  wire logic [11:0]       I_PADDR,
  input  wire logic [31:0]       I_PWDATA,
  output logic      [31:0]       O_PRDATA,
  output logic                   O_PREADY,
  output logic                   O_PSLVERR,
  output logic                   O_RD_VALID,
  output logic      [ADDR_W-1:0] O_RD_ADDR,
  output logic                   O_RD_MARGIN,
  input  wire logic              I_RSP_VALID,
  input  wire logic [31:0]       I_RSP_DATA,
  input  wire logic              I_RSP_EER,
  input  wire logic              I_RSP_SBC,
  output logic                   O_IRQ
);

  // Bus decode shared by read and write paths.
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a[1:0] == 2'b00) && (a <= faic_pkg::MARGIN_OFS);
  endfunction

  faic_pkg::faic_state_t state_reg;
  logic                  brk_en_reg;
  logic [2:0]            read_wait_states_reg;
  logic [1:0]            address_pipeline_setting_reg;
  logic [ADDR_W-1:0]     start_reg;
  logic [ADDR_W-1:0]     end_reg;
  logic [ADDR_W-1:0]     issue_addr_reg;
  logic [ADDR_W-1:0]     err_addr_reg;
  logic [31:0]           signature_register_reg;
  logic                  err_logged_reg;
  logic                  busy_reg;
  logic [3:0]            wait_cnt_reg;
  logic [2:0]            outst_reg;
  logic                  last_issued_reg;
  logic [7:0]            margin_cnt_reg;
  logic [faic_pkg::IRQ_W-1:0] istat_reg;
  logic [faic_pkg::IRQ_W-1:0] imask_reg;
  logic [31:0]           margin_data_reg;
  logic                  brk_pend_reg;
  faic_pkg::faic_rd_rsp_t rsp;

  logic wr_acc;
  logic rd_acc;
  logic ev;
  logic can_issue;
  logic rsp_seen;
  logic [3:0] in_flight;
  logic drain_done;
  logic [faic_pkg::IRQ_W-1:0] irq_set;
  logic [31:0] ctrl_w;

  // Gather the array answer into one carrier, driven as one whole word.
  assign rsp = {I_RSP_VALID, I_RSP_DATA, I_RSP_EER, I_RSP_SBC};

  // APB access phase strobes; the slave answers with zero wait states.
  assign wr_acc = I_PSEL && I_PENABLE && I_PWRITE;
  assign rd_acc = I_PSEL && I_PENABLE && !I_PWRITE;
  assign ctrl_w = (wr_acc && I_PADDR == faic_pkg::CTRL_OFS) ? I_PWDATA : faic_pkg::ZERO_WORD;

  // An event is a check read answer flagged with an event error or correction; margin answers are not events.
  assign ev = rsp.valid && (rsp.ecc_event_error || rsp.single_bit_correction) && state_reg != faic_pkg::FAIC_MARGIN;
  assign rsp_seen = rsp.valid && outst_reg != 3'h0;

  // Reads in flight, counting the request that stands on the link this cycle.
  // The outstanding counter sees a request only one cycle after it leaves; counting the
  // standing request here keeps the pipeline limit, the end of the drain and the
  // recorded event address exact.
  assign in_flight  = {1'b0, outst_reg} + {3'h0, O_RD_VALID && !O_RD_MARGIN};
  assign drain_done = (in_flight == 4'h0) || (in_flight == 4'h1 && rsp_seen);

  // A new read may go out only when the wait count is spent and the pipeline has room.
  assign can_issue = (wait_cnt_reg == 4'h0) && !last_issued_reg &&
                     (in_flight <= {2'b00, address_pipeline_setting_reg});

  // APB answer is immediate; unmapped addresses error.
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_PREADY  <= 1'b0;
      O_PSLVERR <= 1'b0;
      O_PRDATA  <= faic_pkg::ZERO_WORD;
    end else begin
      O_PREADY  <= I_PSEL && !I_PENABLE;
      O_PSLVERR <= I_PSEL && !I_PENABLE && !is_mapped(I_PADDR);
      if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
        case (I_PADDR)
          faic_pkg::CTRL_OFS:   O_PRDATA <= {30'h0, brk_en_reg, busy_reg};
          faic_pkg::CFG_OFS:    O_PRDATA <= {26'h0, address_pipeline_setting_reg, 1'b0,
                                             read_wait_states_reg};
          faic_pkg::START_OFS:  O_PRDATA <= {{(32-ADDR_W){1'b0}}, start_reg};
          faic_pkg::END_OFS:    O_PRDATA <= {{(32-ADDR_W){1'b0}}, end_reg};
          faic_pkg::STAT_OFS:   O_PRDATA <= {27'h0, state_reg, err_logged_reg, busy_reg};
          faic_pkg::SIG_OFS:    O_PRDATA <= signature_register_reg;
          faic_pkg::ERRA_OFS:   O_PRDATA <= {{(32-ADDR_W){1'b0}}, err_addr_reg};
          faic_pkg::CURA_OFS:   O_PRDATA <= {{(32-ADDR_W){1'b0}}, issue_addr_reg};
          faic_pkg::ISTAT_OFS:  O_PRDATA <= {27'h0, istat_reg};
          faic_pkg::IMASK_OFS:  O_PRDATA <= {27'h0, imask_reg};
          faic_pkg::MARGIN_OFS: O_PRDATA <= margin_data_reg;
          default:              O_PRDATA <= faic_pkg::ZERO_WORD;
        endcase
      end
    end
  end

  // Software-written configuration.
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      brk_en_reg                   <= 1'b0;
      read_wait_states_reg         <= 3'h0;
      address_pipeline_setting_reg <= 2'h0;
      start_reg                    <= '0;
      end_reg                      <= '0;
      imask_reg                    <= '0;
    end else if (wr_acc && !busy_reg) begin
      case (I_PADDR)
        faic_pkg::CTRL_OFS:  brk_en_reg <= I_PWDATA[faic_pkg::CTRL_BRK_EN_BIT];
        faic_pkg::CFG_OFS: begin
          read_wait_states_reg         <= I_PWDATA[faic_pkg::CFG_RWS_LSB +: 3];
          address_pipeline_setting_reg <= I_PWDATA[faic_pkg::CFG_APS_LSB +: 2];
        end
        faic_pkg::START_OFS: start_reg <= I_PWDATA[ADDR_W-1:0];
        faic_pkg::END_OFS:   end_reg   <= I_PWDATA[ADDR_W-1:0];
        faic_pkg::IMASK_OFS: imask_reg <= I_PWDATA[faic_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end else if (wr_acc && I_PADDR == faic_pkg::IMASK_OFS) begin
      imask_reg <= I_PWDATA[faic_pkg::IRQ_W-1:0];
    end
  end

  // Check sequencer: issue, wait, break and margin states.
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      state_reg       <= faic_pkg::FAIC_IDLE;
      busy_reg        <= 1'b0;
      issue_addr_reg  <= '0;
      wait_cnt_reg    <= 4'h0;
      last_issued_reg <= 1'b0;
      margin_cnt_reg  <= 8'h0;
      brk_pend_reg    <= 1'b0;
      O_RD_VALID      <= 1'b0;
      O_RD_ADDR       <= '0;
      O_RD_MARGIN     <= 1'b0;
    end else begin
      O_RD_VALID  <= 1'b0;
      O_RD_MARGIN <= 1'b0;
      if (wait_cnt_reg != 4'h0) begin
        wait_cnt_reg <= wait_cnt_reg - 4'h1;
      end
      case (state_reg)
        faic_pkg::FAIC_IDLE: begin
          if (ctrl_w[faic_pkg::CTRL_GO_BIT]) begin
            state_reg       <= faic_pkg::FAIC_ISSUE;
            busy_reg        <= 1'b1;
            issue_addr_reg  <= start_reg;
            last_issued_reg <= 1'b0;
            wait_cnt_reg    <= 4'h0;
            brk_pend_reg    <= 1'b0;
          end else if (ctrl_w[faic_pkg::CTRL_MARGIN_BIT]) begin
            state_reg      <= faic_pkg::FAIC_MARGIN;
            busy_reg       <= 1'b1;
            O_RD_VALID     <= 1'b1;
            O_RD_MARGIN    <= 1'b1;
            O_RD_ADDR      <= start_reg;
            margin_cnt_reg <= 8'(faic_pkg::MARGIN_CYCLES);
          end
        end
        faic_pkg::FAIC_ISSUE: begin
          if (ctrl_w[faic_pkg::CTRL_ABORT_BIT]) begin
            state_reg <= faic_pkg::FAIC_WAIT;
            last_issued_reg <= 1'b1;
          end else if (ev && brk_en_reg) begin
            state_reg <= faic_pkg::FAIC_BREAK;
          end else if (can_issue) begin
            O_RD_VALID   <= 1'b1;
            O_RD_ADDR    <= issue_addr_reg;
            wait_cnt_reg <= {1'b0, read_wait_states_reg};
            if (issue_addr_reg == end_reg) begin
              last_issued_reg <= 1'b1;
              state_reg       <= faic_pkg::FAIC_WAIT;
            end else begin
              issue_addr_reg <= issue_addr_reg + 1'b1;
            end
          end
        end
        faic_pkg::FAIC_WAIT: begin
          if (ev && brk_en_reg && !ctrl_w[faic_pkg::CTRL_ABORT_BIT]) begin
            state_reg <= faic_pkg::FAIC_BREAK;
          end else if (drain_done) begin
            state_reg <= faic_pkg::FAIC_IDLE;
            busy_reg  <= 1'b0;
          end
        end
        faic_pkg::FAIC_BREAK: begin
          // Reads already in flight still land; issuing stays frozen at the next address.
          // An event that lands while stopped is kept, and the resume that follows stops
          // again at once, so back-to-back events each get a stop of their own.
          if (ctrl_w[faic_pkg::CTRL_ABORT_BIT]) begin
            state_reg       <= faic_pkg::FAIC_WAIT;
            last_issued_reg <= 1'b1;
            brk_pend_reg    <= 1'b0;
          end else if (ctrl_w[faic_pkg::CTRL_RESUME_BIT]) begin
            brk_pend_reg <= 1'b0;
            if (!(brk_pend_reg || ev)) begin
              state_reg <= last_issued_reg ? faic_pkg::FAIC_WAIT : faic_pkg::FAIC_ISSUE;
            end
          end else if (ev) begin
            brk_pend_reg <= 1'b1;
          end
        end
        faic_pkg::FAIC_MARGIN: begin
          if (margin_cnt_reg != 8'h0) begin
            margin_cnt_reg <= margin_cnt_reg - 8'h1;
          end else begin
            state_reg <= faic_pkg::FAIC_IDLE;
            busy_reg  <= 1'b0;
          end
        end
        default: begin
          state_reg <= faic_pkg::FAIC_IDLE;
          busy_reg  <= 1'b0;
        end
      endcase
    end
  end

  // Count reads in flight so the pipeline depth is honoured.
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      outst_reg <= 3'h0;
    end else if (O_RD_VALID && !O_RD_MARGIN && !rsp_seen) begin
      outst_reg <= outst_reg + 3'h1;
    end else if (!(O_RD_VALID && !O_RD_MARGIN) && rsp_seen) begin
      outst_reg <= outst_reg - 3'h1;
    end
  end

  // Signature register folds every check read answer in.
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      signature_register_reg <= faic_pkg::SIG_SEED;
    end else if (state_reg == faic_pkg::FAIC_IDLE && ctrl_w[faic_pkg::CTRL_GO_BIT]) begin
      signature_register_reg <= faic_pkg::SIG_SEED;
    end else if (rsp_seen && state_reg != faic_pkg::FAIC_MARGIN) begin
      signature_register_reg <= {signature_register_reg[30:0], 1'b0} ^
        (signature_register_reg[31] ? faic_pkg::SIG_POLY : faic_pkg::ZERO_WORD) ^
        rsp.data;
    end
  end

  // Event logging: first event address, or each breakpoint address.
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      err_logged_reg <= 1'b0;
      err_addr_reg   <= '0;
    end else if (state_reg == faic_pkg::FAIC_IDLE && ctrl_w[faic_pkg::CTRL_GO_BIT]) begin
      err_logged_reg <= 1'b0;
    end else if (ev && (brk_en_reg || !err_logged_reg)) begin
      err_logged_reg <= 1'b1;
      err_addr_reg   <= issue_addr_reg - ADDR_W'(in_flight) + ADDR_W'(last_issued_reg);
    end
  end

  // Margin result capture, apart from the check path.
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      margin_data_reg <= faic_pkg::ZERO_WORD;
    end else if (state_reg == faic_pkg::FAIC_MARGIN && rsp.valid) begin
      margin_data_reg <= rsp.data;
    end
  end

  // Sticky interrupt status; set wins over write-one-to-clear.
  assign irq_set[faic_pkg::IRQ_DONE_BIT]  = state_reg == faic_pkg::FAIC_WAIT && drain_done &&
                                            !(ev && brk_en_reg &&
                                              !ctrl_w[faic_pkg::CTRL_ABORT_BIT]);
  // A stop is flagged when an event halts the check, and again on a resume that finds
  // an event kept while stopped.
  assign irq_set[faic_pkg::IRQ_BREAK_BIT] = (ev && brk_en_reg &&
                                             state_reg != faic_pkg::FAIC_BREAK &&
                                             !ctrl_w[faic_pkg::CTRL_ABORT_BIT]) ||
                                            (state_reg == faic_pkg::FAIC_BREAK &&
                                             !ctrl_w[faic_pkg::CTRL_ABORT_BIT] &&
                                             ctrl_w[faic_pkg::CTRL_RESUME_BIT] &&
                                             (brk_pend_reg || ev));
  assign irq_set[faic_pkg::IRQ_EER_BIT]   = ev && rsp.ecc_event_error;
  assign irq_set[faic_pkg::IRQ_SBC_BIT]   = ev && rsp.single_bit_correction;
  assign irq_set[faic_pkg::IRQ_MDONE_BIT] = state_reg == faic_pkg::FAIC_MARGIN &&
                                            margin_cnt_reg == 8'h0;

  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      istat_reg <= '0;
      O_IRQ     <= 1'b0;
    end else begin
      istat_reg <= (istat_reg & ~((wr_acc && I_PADDR == faic_pkg::ISTAT_OFS) ?
                   I_PWDATA[faic_pkg::IRQ_W-1:0] : {faic_pkg::IRQ_W{1'b0}})) | irq_set;
      O_IRQ     <= |(istat_reg & imask_reg);
    end
  end

endmodule

// *** faic_flash.sv ***
// Behavioural flash array that answers reads in order after a chosen latency.
`timescale 1ns/1ps
module faic_flash #(
  parameter logic [23:0] EV_ADDR = 24'h000014
) (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic [1:0]  i_lat,
  input  wire logic        i_valid,
  input  wire logic [23:0] i_addr,
  output logic             o_valid,
  output logic      [31:0] o_data,
  output logic             o_eer,
  output logic             o_sbc
);
  logic [3:0]  v_reg;
  logic [23:0] a_reg [4];
  wire  [23:0] a = a_reg[i_lat];
  // Requests move one stage per clock and leave at the stage the bench picks.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      v_reg <= 4'h0;
    end else begin
      v_reg <= {v_reg[2:0], i_valid};
    end
  end
  // Address stages carry no reset; they only matter beside a valid stage.
  always_ff @(posedge i_clk) begin
    a_reg[0] <= i_addr;
    a_reg[1] <= a_reg[0];
    a_reg[2] <= a_reg[1];
    a_reg[3] <= a_reg[2];
  end
  // Outside an answer the data is inverted so that stale words never match.
  assign o_valid = v_reg[i_lat];
  assign o_data  = (o_valid ? 32'h5a00_0000 : 32'ha5ff_ffff) ^ {8'h00, a};
  assign o_eer   = o_valid && (a == EV_ADDR);
  assign o_sbc   = o_valid && (a == EV_ADDR + 24'h1);
endmodule

// *** faic_mon_checker.sv ***
// Concurrent checks on the ports of the flash array integrity checker.
`timescale 1ns/1ps
module faic_mon #(
  parameter int ADDR_W = 24
) (
  input wire logic              I_REF_CLK,
  input wire logic              I_RSTN,
  input wire logic              I_PSEL,
  input wire logic              I_PENABLE,
  input wire logic              I_PWRITE,
  input wire logic [11:0]       I_PADDR,
  input wire logic [31:0]       I_PWDATA,
  input wire logic [31:0]       O_PRDATA,
  input wire logic              O_PREADY,
  input wire logic              O_PSLVERR,
  input wire logic              O_RD_VALID,
  input wire logic [ADDR_W-1:0] O_RD_ADDR,
  input wire logic              O_RD_MARGIN,
  input wire logic              I_RSP_VALID,
  input wire logic [31:0]       I_RSP_DATA,
  input wire logic              I_RSP_EER,
  input wire logic              I_RSP_SBC,
  input wire logic              O_IRQ
);
  logic              brk_reg, pend_reg, pend_d_reg, have_reg;
  logic [2:0]        rws_reg;
  logic [3:0]        gap_reg;
  logic [ADDR_W-1:0] prev_reg, start_reg;
  wire wr  = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE;
  wire ctl = wr && (I_PADDR == faic_pkg::CTRL_OFS);
  // Shadow of the settings that software wrote, taken when the write lands.
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rws_reg <= 3'h0;
      start_reg <= '0;
      brk_reg <= 1'b0;
    end else begin
      if (wr && I_PADDR == faic_pkg::CFG_OFS) rws_reg <= I_PWDATA[2:0];
      if (wr && I_PADDR == faic_pkg::START_OFS) start_reg <= I_PWDATA[ADDR_W-1:0];
      if (ctl) brk_reg <= I_PWDATA[1];
    end
  end
  // Last issued address, cycles since that read, and a breakpoint awaiting resume.
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      have_reg <= 1'b0;
      prev_reg <= '0;
      gap_reg <= 4'h0;
      pend_reg <= 1'b0;
      pend_d_reg <= 1'b0;
    end else begin
      if (ctl && I_PWDATA[0]) have_reg <= 1'b0;
      else if (O_RD_VALID && !O_RD_MARGIN) have_reg <= 1'b1;
      if (O_RD_VALID && !O_RD_MARGIN) prev_reg <= O_RD_ADDR;
      if (O_RD_VALID) gap_reg <= 4'h0;
      else if (gap_reg != 4'hf) gap_reg <= gap_reg + 4'h1;
      if (ctl && |I_PWDATA[3:0]) pend_reg <= 1'b0;
      else if (I_RSP_VALID && (I_RSP_EER || I_RSP_SBC) && brk_reg) pend_reg <= 1'b1;
      pend_d_reg <= pend_reg;
    end
  end
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RSTN);
  sequence s_setup; I_PSEL && !I_PENABLE; endsequence
  sequence s_access; I_PSEL && I_PENABLE && O_PREADY; endsequence
  a_ready_setup: assert property (s_setup |=> s_access)
    else $error("no ready in access cycle");
  a_ready_pulse: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready longer than one cycle");
  a_err_ready: assert property (O_PSLVERR |-> O_PREADY)
    else $error("slave error without ready");
  a_err_zero: assert property (O_PREADY && O_PSLVERR && !I_PWRITE |-> O_PRDATA == 32'h0)
    else $error("refused read returned data");
  a_wait_gap: assert property (O_RD_VALID && !O_RD_MARGIN && have_reg |-> gap_reg >= rws_reg)
    else $error("reads closer than wait states");
  a_addr_step: assert property (O_RD_VALID && !O_RD_MARGIN && have_reg
                               |-> O_RD_ADDR == ADDR_W'(prev_reg + 1'b1))
    else $error("read address not consecutive");
  a_margin_addr: assert property (O_RD_MARGIN |-> O_RD_VALID && O_RD_ADDR == start_reg)
    else $error("margin read misplaced");
  a_break_hold: assert property (pend_reg && pend_d_reg |-> !O_RD_VALID)
    else $error("read issued during breakpoint");
endmodule
bind faic_checker faic_mon #(.ADDR_W(ADDR_W)) u_mon (
  .I_REF_CLK(I_REF_CLK), .I_RSTN(I_RSTN), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA),
  .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_RD_VALID(O_RD_VALID),
  .O_RD_ADDR(O_RD_ADDR), .O_RD_MARGIN(O_RD_MARGIN), .I_RSP_VALID(I_RSP_VALID),
  .I_RSP_DATA(I_RSP_DATA), .I_RSP_EER(I_RSP_EER), .I_RSP_SBC(I_RSP_SBC), .O_IRQ(O_IRQ)
);

// *** faic_pkg.sv ***
// Package with constants, types and register map of the flash array integrity checker.
package faic_pkg;

  // Register byte offsets.
  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] CFG_OFS    = 12'h004;
  localparam logic [11:0] START_OFS  = 12'h008;
  localparam logic [11:0] END_OFS    = 12'h00c;
  localparam logic [11:0] STAT_OFS   = 12'h010;
  localparam logic [11:0] SIG_OFS    = 12'h014;
  localparam logic [11:0] ERRA_OFS   = 12'h018;
  localparam logic [11:0] CURA_OFS   = 12'h01c;
  localparam logic [11:0] ISTAT_OFS  = 12'h020;
  localparam logic [11:0] IMASK_OFS  = 12'h024;
  localparam logic [11:0] MARGIN_OFS = 12'h028;

  // Control register bits.
  localparam int CTRL_GO_BIT     = 0;
  localparam int CTRL_BRK_EN_BIT = 1;
  localparam int CTRL_RESUME_BIT = 2;
  localparam int CTRL_ABORT_BIT  = 3;
  localparam int CTRL_MARGIN_BIT = 4;

  // Configuration field positions: read wait states [2:0], pipeline setting [5:4].
  localparam int CFG_RWS_LSB = 0;
  localparam int CFG_APS_LSB = 4;

  // Interrupt status bits.
  localparam int IRQ_DONE_BIT   = 0;
  localparam int IRQ_BREAK_BIT  = 1;
  localparam int IRQ_EER_BIT    = 2;
  localparam int IRQ_SBC_BIT    = 3;
  localparam int IRQ_MDONE_BIT  = 4;
  localparam int IRQ_W          = 5;

  // Reset values and constants.
  localparam logic [31:0] SIG_SEED   = 32'hffff_ffff;
  localparam logic [31:0] SIG_POLY   = 32'h04c1_1db7;
  localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;
  localparam logic [31:0] STRAP_ID   = 32'h0a5a_0001; // Arbitrary value.

  // Margin read is self timed: a fixed time regardless of wait states.
  localparam int MARGIN_NS      = 1000;
  localparam int CLK_PERIOD_NS  = 100;
  localparam int MARGIN_CYCLES  = (MARGIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Checker states.
  typedef enum logic [2:0] {
    FAIC_IDLE   = 3'b000,
    FAIC_ISSUE  = 3'b001,
    FAIC_WAIT   = 3'b010,
    FAIC_BREAK  = 3'b011,
    FAIC_MARGIN = 3'b100
  } faic_state_t;

  // Read request toward the flash array.
  typedef struct packed {
    logic        valid;
    logic [23:0] addr;
    logic        margin;
  } faic_rd_req_t;

  // Read answer from the flash array.
  typedef struct packed {
    logic        valid;
    logic [31:0] data;
    logic        ecc_event_error;
    logic        single_bit_correction;
  } faic_rd_rsp_t;

endpackage

// *** flash_array_integrity_checker_tb.sv ***
// Self-checking testbench for the flash array integrity checker.
`timescale 1ns/1ps
module flash_array_integrity_checker_tb;
  localparam logic [23:0] EV = 24'h000014;
  logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rspd, rdat;
  logic        pready, pslverr, rdv, rdm, rspv, ecc_event_error, single_bit_correction, irq, rerr;
  logic [23:0] rda;
  logic [1:0]  lat = 2'h0;
  int          num_errors = 0;
  int          n_tests = 0;
  // Clock of 100 ns period.
  always #50 clk = ~clk;
  faic_checker dut (
    .I_REF_CLK(clk), .I_RSTN(rstn), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .O_RD_VALID(rdv), .O_RD_ADDR(rda), .O_RD_MARGIN(rdm),
    .I_RSP_VALID(rspv), .I_RSP_DATA(rspd), .I_RSP_EER(ecc_event_error), .I_RSP_SBC(single_bit_correction), .O_IRQ(irq));
  faic_flash #(.EV_ADDR(EV)) u_flash (
    .i_clk(clk), .i_rstn(rstn), .i_lat(lat), .i_valid(rdv), .i_addr(rda),
    .o_valid(rspv), .o_data(rspd), .o_eer(ecc_event_error), .o_sbc(single_bit_correction));
  // Prints the verdict and ends the run.
  task conclude;
    if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One APB transfer; read data and error are taken at the ready edge.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // Expected signature over an inclusive address range.
  function automatic logic [31:0] sig_of(input logic [23:0] s, input logic [23:0] e);
    logic [31:0] r;
    r = faic_pkg::SIG_SEED;
    for (logic [23:0] a = s; a <= e; a++)
      r = {r[30:0], 1'b0} ^ (r[31] ? faic_pkg::SIG_POLY : 32'h0) ^ 32'h5a00_0000 ^ {8'h00, a};
    return r;
  endfunction
  task t_regs;
    apb(1'b0, faic_pkg::SIG_OFS, 32'h0);
    chk("sig_reset", rdat, faic_pkg::SIG_SEED);
    apb(1'b0, 12'h3fc, 32'h0);
    chk("unmapped_err", {31'h0, rerr}, 32'h1);
    chk("unmapped_data", rdat, 32'h0);
  endtask
  // Full check over 0x10..0x1f with two back-to-back events at EV and EV+1.
  task t_run(input logic [2:0] rws, input logic [1:0] aps, input logic brk, input logic [1:0] l);
    int nb;
    lat <= l;
    apb(1'b1, faic_pkg::CFG_OFS, {26'h0, aps, 1'b0, rws});
    apb(1'b1, faic_pkg::START_OFS, 32'h10);
    apb(1'b1, faic_pkg::END_OFS, 32'h1f);
    apb(1'b1, faic_pkg::ISTAT_OFS, 32'h1f);
    apb(1'b1, faic_pkg::IMASK_OFS, 32'h1);
    apb(1'b1, faic_pkg::CTRL_OFS, {30'h0, brk, 1'b1});
    nb = 0;
    rdat = 32'h0;
    for (int i = 0; i < 300 && rdat[0] !== 1'b1; i++) begin
      apb(1'b0, faic_pkg::ISTAT_OFS, 32'h0);
      if (rdat[1] === 1'b1 && rdat[0] !== 1'b1) begin
        nb++;
        chk("irq_masked", {31'h0, irq}, 32'h0);
        repeat (20) @(posedge clk);
        apb(1'b1, faic_pkg::ISTAT_OFS, 32'h2);
        apb(1'b1, faic_pkg::CTRL_OFS, 32'h6);
      end
    end
    chk("breaks", 32'(nb), brk ? 32'h2 : 32'h0);
    chk("irq_done", {31'h0, irq}, 32'h1);
    apb(1'b0, faic_pkg::SIG_OFS, 32'h0);
    chk("signature", rdat, sig_of(24'h10, 24'h1f));
    apb(1'b0, faic_pkg::STAT_OFS, 32'h0);
    chk("err_logged", {31'h0, rdat[1]}, 32'h1);
    if (!brk) begin
      apb(1'b0, faic_pkg::ERRA_OFS, 32'h0);
      chk("first_event", rdat, {8'h00, EV});
    end
    apb(1'b1, faic_pkg::ISTAT_OFS, 32'h1f);
    repeat (2) @(posedge clk);
    chk("irq_clear", {31'h0, irq}, 32'h0);
  endtask
  // Abort from a breakpoint: the check drains, flags done and keeps the next address.
  task t_abort;
    apb(1'b1, faic_pkg::CFG_OFS, 32'h11);
    apb(1'b1, faic_pkg::ISTAT_OFS, 32'h1f);
    apb(1'b1, faic_pkg::CTRL_OFS, 32'h3);
    rdat = 32'h0;
    for (int i = 0; i < 100 && rdat[1] !== 1'b1; i++) apb(1'b0, faic_pkg::ISTAT_OFS, 32'h0);
    apb(1'b1, faic_pkg::CTRL_OFS, 32'h8);
    repeat (10) @(posedge clk);
    apb(1'b0, faic_pkg::ISTAT_OFS, 32'h0);
    chk("abort_flags", {30'h0, rdat[1:0]}, 32'h3);
    apb(1'b0, faic_pkg::STAT_OFS, 32'h0);
    chk("abort_idle", {31'h0, rdat[0]}, 32'h0);
    apb(1'b0, faic_pkg::CURA_OFS, 32'h0);
    chk("abort_next", rdat, 32'h15);
  endtask
  // Margin read of a fresh start address with five read wait states.
  task t_margin;
    apb(1'b1, faic_pkg::CFG_OFS, 32'h25);
    apb(1'b1, faic_pkg::START_OFS, 32'h33);
    apb(1'b1, faic_pkg::ISTAT_OFS, 32'h1f);
    apb(1'b1, faic_pkg::CTRL_OFS, 32'h10);
    rdat = 32'h0;
    for (int i = 0; i < 50 && rdat[4] !== 1'b1; i++) apb(1'b0, faic_pkg::ISTAT_OFS, 32'h0);
    chk("margin_done", {31'h0, rdat[4]}, 32'h1);
    apb(1'b0, faic_pkg::MARGIN_OFS, 32'h0);
    chk("margin_data", rdat, 32'h5a00_0033);
  endtask
  // Main sequence: reset, register checks, nine check runs, abort, margin read.
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_regs;
    t_run(3'd0, 2'd0, 1'b1, 2'd0);
    t_run(3'd2, 2'd1, 1'b1, 2'd0);
    t_run(3'd3, 2'd1, 1'b0, 2'd0);
    t_run(3'd4, 2'd1, 1'b1, 2'd1);
    t_run(3'd5, 2'd2, 1'b1, 2'd0);
    t_run(3'd1, 2'd1, 1'b1, 2'd0);
    t_run(3'd3, 2'd2, 1'b1, 2'd1);
    t_run(3'd5, 2'd3, 1'b1, 2'd2);
    t_run(3'd1, 2'd1, 1'b0, 2'd0);
    t_abort;
    t_margin;
    conclude;
  end
  // Watchdog against a hang.
  initial begin
    #(100 * 40000);
    num_errors++;
    conclude;
  end
endmodule
